/* File: verilog/bridge_params.svh */
// constants for the bridge dead time and bootstrap charge block
// Function
// RULE1 - after one FET turns off, delay its complement's turn-on by the dead interval
// RULE2 - one dead-interval setting serves all three phases alike
// RULE3 - setting tied to ground inserts no internal dead interval
// RULE4 - setting tied to logic supply gives the largest interval, 6 us
// RULE5 - delay only on-commands arriving within the interval after the complement's off
// RULE6 - with one side always off, the other turns on without dead interval
// RULE7 - ignore a FET's drain-source monitor while off and while blanking after on
// RULE8 - blanking equals dead interval plus a 300 to 600 ns monitor allowance
// RULE9 - with zero dead interval, blanking defaults to 2 us
// RULE10 - both FETs of a phase on only with zero interval and cross enable high
// RULE11 - the controller holds cross enable low to forbid overlap at zero interval
// RULE12 - watch each phase's bootstrap voltage against its undervoltage threshold continuously
// RULE13 - below threshold, force low side on until above threshold plus hysteresis
// RULE14 - each forced charge lasts at least 7 us
// RULE15 - no recovery within about 200 us of charging flags bootstrap undervoltage
// RULE16 - bootstrap undervoltage latches a per-phase flag in the fault register
// RULE17 - drain-source fault outside blanking latches a flag naming phase and side
// RULE18 - all durations are clock counts; comparator inputs are synchronised before use
// RULE19 - a forced charge turns the high side off first and honours the interval
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH

`define CLK_MHZ 250
`define DEAD_MAX_NS 6000
`define BLANK_COMP_NS 300
`define BLANK_ZERO_NS 2000
`define MIN_CHARGE_NS 7000
`define BOOT_TIMEOUT_US 200
`define DEAD_MAX_CYC ((`DEAD_MAX_NS * `CLK_MHZ + 999) / 1000)
`define BLANK_COMP_CYC ((`BLANK_COMP_NS * `CLK_MHZ + 999) / 1000)
`define BLANK_ZERO_CYC ((`BLANK_ZERO_NS * `CLK_MHZ + 999) / 1000)
`define MIN_CHARGE_CYC ((`MIN_CHARGE_NS * `CLK_MHZ + 999) / 1000)
`define BOOT_TIMEOUT_CYC (`BOOT_TIMEOUT_US * `CLK_MHZ)

`define REG_CTRL 8'h00
`define REG_DEAD_CYC 8'h04
`define REG_FAULT 8'h08
`define REG_FAULT_MASK 8'h0C
`define REG_STATE 8'h10

`define CTRL_RESET 32'h0000_0001
`define DEAD_CYC_RESET 32'h0000_0064
`define FAULT_MASK_RESET 32'h0000_0000
`define FAULT_VDS_HIGH_POS 0
`define FAULT_VDS_LOW_POS 3
`define FAULT_BOOT_UV_POS 7
`define FAULT_USED_MASK 32'h0000_03BF

`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

/* File: verilog/bridge_pkg.sv */
// types shared by the bridge dead time and bootstrap charge block
package bridge_pkg;
  typedef logic [15:0] cyc_t;
  typedef enum logic [1:0] {
    DEAD_ZERO = 2'h0,
    DEAD_MAX = 2'h1,
    DEAD_PROG = 2'h2
  } dead_mode_t;
  typedef enum {BOOT_IDLE, BOOT_CHARGE} boot_state_t;
endpackage

/* File: verilog/phase_ctl_if.sv */
// per-phase control carried between the top, bootstrap and gate logic
interface phase_ctl_if;
  import bridge_pkg::*;
  cyc_t dead_cyc;
  cyc_t blank_cyc;
  logic cross_ok;
  logic force_low;
  logic charging;
  modport ctl (output dead_cyc, output blank_cyc, output cross_ok, input charging);
  modport boot (output force_low, output charging);
  modport gate (input dead_cyc, input blank_cyc, input cross_ok, input force_low);
endinterface

/* File: verilog/boot_charge.sv */
// automatic bootstrap charge manager for one phase
`include "bridge_params.svh"
module boot_charge
  import bridge_pkg::*;
#(
  parameter int TIMEOUT_CYC = `BOOT_TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic boot_below,
  input wire logic boot_above_hys,
  phase_ctl_if.boot ctl,
  output logic uv_event
);
  boot_state_t state_ff;
  logic [17:0] cnt_ff;
  logic min_done;
  logic timed_out;

  assign min_done = cnt_ff >= 18'(`MIN_CHARGE_CYC);
  assign timed_out = cnt_ff == 18'(TIMEOUT_CYC);

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= BOOT_IDLE;
    end else begin
      case (state_ff)
        BOOT_IDLE: if (boot_below) state_ff <= BOOT_CHARGE; // RULE12 RULE13
        BOOT_CHARGE: if (min_done && boot_above_hys) state_ff <= BOOT_IDLE; // RULE13 RULE14
        default: state_ff <= BOOT_IDLE;
      endcase
    end
  end

  // counter saturates past timeout so the fault fires once per charge
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff != BOOT_CHARGE) begin
      cnt_ff <= 18'h0;
    end else if (cnt_ff <= 18'(TIMEOUT_CYC)) begin
      cnt_ff <= cnt_ff + 18'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) uv_event <= 1'b0;
    else uv_event <= state_ff == BOOT_CHARGE && timed_out && !boot_above_hys; // RULE15
  end

  assign ctl.force_low = state_ff == BOOT_CHARGE; // RULE13
  assign ctl.charging = state_ff == BOOT_CHARGE;
endmodule

/* File: verilog/phase_gate.sv */
// dead time insertion and drain-source blanking for one half bridge
`include "bridge_params.svh"
module phase_gate
  import bridge_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_high,
  input wire logic cmd_low,
  input wire logic vds_high_over,
  input wire logic vds_low_over,
  phase_ctl_if.gate ctl,
  output logic gate_high_ff,
  output logic gate_low_ff,
  output logic vds_high_event,
  output logic vds_low_event
);
  cyc_t off_high_ff;
  cyc_t off_low_ff;
  cyc_t on_high_ff;
  cyc_t on_low_ff;
  logic want_high;
  logic want_low;
  logic nxt_gate_high;
  logic nxt_gate_low;

  // forced charge pulls the high side off first; low then waits the interval
  assign want_high = cmd_high && !ctl.force_low; // RULE19
  assign want_low = cmd_low || ctl.force_low; // RULE13

  // off counters start saturated so a side that was never on costs no delay
  always_comb begin
    nxt_gate_low = want_low && (ctl.cross_ok ||
      (!gate_high_ff && off_high_ff >= ctl.dead_cyc)); // RULE1 RULE5 RULE6 RULE10
    nxt_gate_high = want_high && (ctl.cross_ok ||
      (!gate_low_ff && off_low_ff >= ctl.dead_cyc && !nxt_gate_low)); // RULE1 RULE5 RULE10
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_high_ff <= 1'b0;
      gate_low_ff <= 1'b0;
    end else begin
      gate_high_ff <= nxt_gate_high;
      gate_low_ff <= nxt_gate_low;
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_high_ff <= 16'hFFFF;
      off_low_ff <= 16'hFFFF;
    end else begin
      if (gate_high_ff) off_high_ff <= 16'h0;
      else if (off_high_ff != 16'hFFFF) off_high_ff <= off_high_ff + 16'h1; // RULE18
      if (gate_low_ff) off_low_ff <= 16'h0;
      else if (off_low_ff != 16'hFFFF) off_low_ff <= off_low_ff + 16'h1; // RULE18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_high_ff <= 16'h0;
      on_low_ff <= 16'h0;
    end else begin
      if (!gate_high_ff) on_high_ff <= 16'h0;
      else if (on_high_ff != 16'hFFFF) on_high_ff <= on_high_ff + 16'h1;
      if (!gate_low_ff) on_low_ff <= 16'h0;
      else if (on_low_ff != 16'hFFFF) on_low_ff <= on_low_ff + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vds_high_event <= 1'b0;
      vds_low_event <= 1'b0;
    end else begin
      vds_high_event <= gate_high_ff && on_high_ff >= ctl.blank_cyc && vds_high_over; // RULE7
      vds_low_event <= gate_low_ff && on_low_ff >= ctl.blank_cyc && vds_low_over; // RULE7
    end
  end
endmodule

/* File: verilog/bridge_dead_time_and_boot_charge.sv */
// three-phase gate conditioning with dead time, blanking and bootstrap charge
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`include "bridge_params.svh"
module bridge_dead_time_and_boot_charge
  import bridge_pkg::*;
#(
  parameter int BOOT_TIMEOUT_CYC = `BOOT_TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller commands, same clock
  input wire logic [2:0] cmd_high,
  input wire logic [2:0] cmd_low,
  // pins and comparators, asynchronous
  input wire logic cross_conduction_enable,
  input wire logic [2:0] boot_below,
  input wire logic [2:0] boot_above_hys,
  input wire logic [2:0] vds_high_over,
  input wire logic [2:0] vds_low_over,
  output logic [2:0] gate_high,
  output logic [2:0] gate_low,
  output logic irq
);
  localparam int NSYNC = 13;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic cc_sync;
  logic [2:0] below_sync;
  logic [2:0] above_sync;
  logic [2:0] vh_sync;
  logic [2:0] vl_sync;

  logic [31:0] ctrl_ff;
  logic [31:0] dead_prog_ff;
  logic [31:0] fault_ff;
  logic [31:0] mask_ff;
  logic [31:0] state_word;
  logic [31:0] fault_set;
  logic [31:0] fault_clr;

  dead_mode_t dead_mode;
  cyc_t dead_cyc;
  cyc_t blank_cyc;
  logic zero_dead;

  logic [2:0] vds_high_ev;
  logic [2:0] vds_low_ev;
  logic [2:0] uv_ev;
  logic [2:0] charging;

  logic wr_fire;
  logic rd_fire;
  logic [31:0] wmask;

  ////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = addr == `REG_CTRL || addr == `REG_DEAD_CYC || addr == `REG_FAULT ||
      addr == `REG_FAULT_MASK || addr == `REG_STATE;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
      input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  ////////////////////////////////////////////////////////////////
  // two-flop synchronisers; only sync2 is read
  assign async_in = {cross_conduction_enable, vds_low_over, vds_high_over,
    boot_above_hys, boot_below};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= async_in[gi];
          sync2_ff[gi] <= sync1_ff[gi]; // RULE18
        end
      end
    end
  endgenerate

  assign below_sync = sync2_ff[2:0];
  assign above_sync = sync2_ff[5:3];
  assign vh_sync = sync2_ff[8:6];
  assign vl_sync = sync2_ff[11:9];
  assign cc_sync = sync2_ff[12];

  ////////////////////////////////////////////////////////////////
  // dead interval and blanking selection, shared by every phase
  assign dead_mode = dead_mode_t'(ctrl_ff[1:0]);

  always_comb begin
    case (dead_mode)
      DEAD_ZERO: dead_cyc = 16'h0; // RULE3
      DEAD_MAX: dead_cyc = 16'(`DEAD_MAX_CYC); // RULE4
      DEAD_PROG: dead_cyc = dead_prog_ff[15:0];
      default: dead_cyc = 16'h0;
    endcase
  end

  assign zero_dead = dead_cyc == 16'h0;

  // saturating sum so a huge programmed interval never wraps the blank time
  always_comb begin
    logic [16:0] sum;
    sum = 17'h0;
    if (zero_dead) begin
      blank_cyc = 16'(`BLANK_ZERO_CYC); // RULE9
    end else begin
      sum = {1'b0, dead_cyc} + 17'(`BLANK_COMP_CYC); // RULE8
      blank_cyc = sum[16] ? 16'hFFFF : sum[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // phases
  generate
    for (gi = 0; gi < 3; gi++) begin : g_phase
      phase_ctl_if pc ();

      assign pc.dead_cyc = dead_cyc; // RULE2
      assign pc.blank_cyc = blank_cyc;
      assign pc.cross_ok = zero_dead && cc_sync; // RULE10 RULE11
      assign charging[gi] = pc.charging;

      boot_charge #(
        .TIMEOUT_CYC(BOOT_TIMEOUT_CYC)
      ) u_boot (
        .aclk(aclk),
        .aresetn(aresetn),
        .boot_below(below_sync[gi]),
        .boot_above_hys(above_sync[gi]),
        .ctl(pc.boot),
        .uv_event(uv_ev[gi])
      );

      phase_gate u_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .cmd_high(cmd_high[gi]),
        .cmd_low(cmd_low[gi]),
        .vds_high_over(vh_sync[gi]),
        .vds_low_over(vl_sync[gi]),
        .ctl(pc.gate),
        .gate_high_ff(gate_high[gi]),
        .gate_low_ff(gate_low[gi]),
        .vds_high_event(vds_high_ev[gi]),
        .vds_low_event(vds_low_ev[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // write channel: address and data taken together, response after both
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_fire = s_axi_awready;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= reg_hit(s_axi_awaddr) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `CTRL_RESET;
      dead_prog_ff <= `DEAD_CYC_RESET;
      mask_ff <= `FAULT_MASK_RESET;
    end else if (wr_fire) begin
      if (s_axi_awaddr == `REG_CTRL) ctrl_ff <= merge(ctrl_ff, wmask, s_axi_wdata) & 32'h3;
      if (s_axi_awaddr == `REG_DEAD_CYC) begin
        dead_prog_ff <= merge(dead_prog_ff, wmask, s_axi_wdata) & 32'hFFFF;
      end
      if (s_axi_awaddr == `REG_FAULT_MASK) begin
        mask_ff <= merge(mask_ff, wmask, s_axi_wdata) & `FAULT_USED_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // fault register: sticky, write one to clear, a new event beats the clear
  always_comb begin
    fault_set = 32'h0;
    fault_set[`FAULT_VDS_HIGH_POS +: 3] = vds_high_ev; // RULE17
    fault_set[`FAULT_VDS_LOW_POS +: 3] = vds_low_ev; // RULE17
    fault_set[`FAULT_BOOT_UV_POS +: 3] = uv_ev; // RULE16
  end

  assign fault_clr = (wr_fire && s_axi_awaddr == `REG_FAULT) ? (s_axi_wdata & wmask) : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) fault_ff <= 32'h0;
    else fault_ff <= ((fault_ff & ~fault_clr) | fault_set) & `FAULT_USED_MASK; // RULE16 RULE17
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(fault_ff & mask_ff);
  end

  ////////////////////////////////////////////////////////////////
  // read channel: one cycle to data
  assign state_word = {22'h0, cc_sync, charging, gate_low, gate_high};
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= reg_hit(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
      case (s_axi_araddr)
        `REG_CTRL: s_axi_rdata <= ctrl_ff;
        `REG_DEAD_CYC: s_axi_rdata <= dead_prog_ff;
        `REG_FAULT: s_axi_rdata <= fault_ff;
        `REG_FAULT_MASK: s_axi_rdata <= mask_ff;
        `REG_STATE: s_axi_rdata <= state_word;
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: sim/bridge_dead_time_and_boot_charge_checker.sv */
// port-level assertions for the bridge dead time block
module bridge_dead_time_and_boot_charge_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0] cmd_high,
  input wire logic [2:0] cmd_low,
  input wire logic cross_conduction_enable,
  input wire logic [2:0] boot_below,
  input wire logic [2:0] gate_high,
  input wire logic [2:0] gate_low
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_ANSWER: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  // four samples cover the two-flop sync of the pin
  AST_NO_SHOOT: assert property (!cross_conduction_enable [*4] |-> (gate_high & gate_low) == 3'h0)
    else $error("both gates on without cross enable");
  AST_GATE_CMD: assert property ((gate_high & ~$past(cmd_high)) == 3'h0)
    else $error("high gate on without command");
  AST_DEAD_GAP: assert property (!cross_conduction_enable [*4] |->
    ((gate_high & $past(gate_low) & ~gate_low) | (gate_low & $past(gate_high) & ~gate_high)) == 3'h0)
    else $error("complement on at the edge of turn-off");
  AST_BOOT_DROP: assert property (boot_below[2] [*6] |-> !gate_high[2])
    else $error("high gate kept on during charge");
  ////////////////////////////////////////////////////////////////////////////////
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ((gate_high & gate_low) != 3'h0);
  cover property (gate_low[2] && !cmd_low[2]);
endmodule

bind bridge_dead_time_and_boot_charge bridge_dead_time_and_boot_charge_checker
  u_bridge_dead_time_and_boot_charge_checker (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .cmd_high(cmd_high),
  .cmd_low(cmd_low), .cross_conduction_enable(cross_conduction_enable),
  .boot_below(boot_below), .gate_high(gate_high), .gate_low(gate_low));

/* File: sim/motor_ctrl_model.sv */
// motor controller model: per-FET commands and the cross enable pin
module motor_ctrl_model (
  input wire logic aclk,
  output logic [2:0] cmd_high,
  output logic [2:0] cmd_low,
  output logic cross_conduction_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_high = 3'h0;
    cmd_low = 3'h0;
    cross_conduction_enable = 1'b0;
  end
  task automatic drive(input logic [2:0] h, input logic [2:0] l);
    @(posedge aclk);
    cmd_high <= h;
    cmd_low <= l;
  endtask
  // held low unless a test asks for overlap on purpose
  task automatic set_cc(input logic c);
    @(posedge aclk);
    cross_conduction_enable <= c;
  endtask
endmodule

/* File: sim/bridge_dead_time_and_boot_charge_tb.sv */
// self-checking bench for the bridge dead time and bootstrap block
`include "bridge_params.svh"
module bridge_dead_time_and_boot_charge_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 3000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, cc;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] cmd_high, cmd_low, gate_high, gate_low;
  logic [2:0] boot_below = 3'h0, boot_above_hys = 3'h7, vds_high_over = 3'h0, vds_low_over = 3'h0;
  int seed = 32'h1723AA1E;
  int n_mismatch = 0, compares = 0, cyc = 0;
  bit noise = 1'b0;
  always #2 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  bridge_dead_time_and_boot_charge #(.BOOT_TIMEOUT_CYC(TMO)) u_bridge_dead_time_and_boot_charge (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cmd_high(cmd_high), .cmd_low(cmd_low), .cross_conduction_enable(cc),
    .boot_below(boot_below), .boot_above_hys(boot_above_hys), .vds_high_over(vds_high_over),
    .vds_low_over(vds_low_over), .gate_high(gate_high), .gate_low(gate_low), .irq(irq));
  motor_ctrl_model u_motor_ctrl_model (.aclk(aclk), .cmd_high(cmd_high), .cmd_low(cmd_low),
    .cross_conduction_enable(cc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      close_out();
    end
  end
  // low-side monitor noise while those gates are off must be ignored
  always @(posedge aclk) begin
    if (noise)
      vds_low_over <= 3'($random(seed));
    else
      vds_low_over <= 3'h0;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    axr(a, rd, rs);
    chk(nm, rd, exp);
  endtask
  function automatic int blank_of(input logic [1:0] m, input int d);
    return (m == 2'h0) ? `BLANK_ZERO_CYC : d + `BLANK_COMP_CYC;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // counts reads after the commanding edge; registered gates add one
  task automatic dead_run(input logic [1:0] m, input int d);
    int n;
    axw(`REG_CTRL, {30'h0, m}, rs);
    u_motor_ctrl_model.drive(3'h0, 3'h7);
    repeat (d + 8) @(posedge aclk);
    u_motor_ctrl_model.drive(3'h7, 3'h0);
    n = 0;
    do begin @(posedge aclk); n++; end while (gate_high !== 3'h7 && n < d + 20);
    chk("dead gap", 32'(n), 32'(d + 3));
    u_motor_ctrl_model.drive(3'h0, 3'h0);
    repeat (d + 8) @(posedge aclk);
    u_motor_ctrl_model.drive(3'h7, 3'h0);
    n = 0;
    do begin @(posedge aclk); n++; end while (gate_high !== 3'h7 && n < d + 20);
    chk("late on", 32'(n), 32'h2);
    u_motor_ctrl_model.drive(3'h0, 3'h0);
    done("dead interval");
  endtask
  task automatic blank_run(input logic [1:0] m, input int d, input int ph);
    int b;
    int n;
    b = blank_of(m, d);
    axw(`REG_CTRL, {30'h0, m}, rs);
    axw(`REG_FAULT_MASK, `FAULT_USED_MASK, rs);
    vds_high_over[ph] <= 1'b1;
    noise = 1'b1;
    // low sides off for a whole interval, so the high turn-on is not delayed
    repeat (d + 20) @(posedge aclk);
    chk("off ignored", irq, 32'h0);
    u_motor_ctrl_model.drive(3'h1 << ph, 3'h0);
    n = 0;
    do begin @(posedge aclk); n++; end while (irq !== 1'b1 && n < b + 20);
    chk("blank length", (n > b && n <= b + 10), 32'h1);
    noise = 1'b0;
    rdchk(`REG_FAULT, 32'h1 << ph, "vds flag");
    vds_high_over[ph] <= 1'b0;
    u_motor_ctrl_model.drive(3'h0, 3'h0);
    // synced monitor still raises events for two more cycles; a set beats the clear
    repeat (4) @(posedge aclk);
    axw(`REG_FAULT, `FAULT_USED_MASK, rs);
    chk("clear bresp", rs, `AXI_OKAY);
    rdchk(`REG_FAULT, 32'h0, "vds cleared");
    chk("irq cleared", irq, 32'h0);
    done("blanking");
  endtask
  task automatic boot_run(input int d);
    axw(`REG_CTRL, 32'h2, rs);
    axw(`REG_FAULT_MASK, 32'h0, rs);
    u_motor_ctrl_model.drive(3'h4, 3'h0);
    repeat (4) @(posedge aclk);
    boot_below[2] <= 1'b1;
    boot_above_hys[2] <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("boot high off", gate_high[2], 32'h0);
    repeat (d + 4) @(posedge aclk);
    chk("boot low on", gate_low[2], 32'h1);
    boot_below[2] <= 1'b0;
    boot_above_hys[2] <= 1'b1;
    repeat (1600) @(posedge aclk);
    chk("min charge", gate_low[2], 32'h1);
    repeat (200) @(posedge aclk);
    chk("charge end", gate_low[2], 32'h0);
    boot_below[2] <= 1'b1;
    boot_above_hys[2] <= 1'b0;
    repeat (TMO - 100) @(posedge aclk);
    rdchk(`REG_FAULT, 32'h0, "uv early");
    repeat (200) @(posedge aclk);
    rdchk(`REG_FAULT, 32'h1 << (`FAULT_BOOT_UV_POS + 2), "uv flag");
    chk("uv masked", irq, 32'h0);
    axw(`REG_FAULT_MASK, 32'h1 << (`FAULT_BOOT_UV_POS + 2), rs);
    repeat (3) @(posedge aclk);
    chk("uv irq", irq, 32'h1);
    boot_below[2] <= 1'b0;
    boot_above_hys[2] <= 1'b1;
    repeat (10) @(posedge aclk);
    axw(`REG_FAULT, 32'h1 << (`FAULT_BOOT_UV_POS + 2), rs);
    repeat (3) @(posedge aclk);
    chk("uv irq clear", irq, 32'h0);
    u_motor_ctrl_model.drive(3'h0, 3'h0);
    done("bootstrap");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int d;
    int ph;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(`REG_CTRL, `CTRL_RESET, "ctrl reset");
    rdchk(`REG_DEAD_CYC, `DEAD_CYC_RESET, "dead reset");
    rdchk(`REG_FAULT_MASK, `FAULT_MASK_RESET, "mask reset");
    rdchk(`REG_FAULT, 32'h0, "fault reset");
    rdchk(8'h40, 32'h0, "unmapped read");
    chk("unmapped rresp", rs, `AXI_SLVERR);
    axw(8'h40, 32'hFFFF_FFFF, rs);
    chk("unmapped bresp", rs, `AXI_SLVERR);
    done("registers");
    d = 8 + int'($unsigned($random(seed)) % 32);
    ph = int'($unsigned($random(seed)) % 3);
    axw(`REG_DEAD_CYC, 32'(d), rs);
    dead_run(2'h2, d);
    dead_run(2'h1, `DEAD_MAX_CYC);
    dead_run(2'h0, 0);
    u_motor_ctrl_model.set_cc(1'b1);
    repeat (4) @(posedge aclk);
    u_motor_ctrl_model.drive(3'h7, 3'h7);
    repeat (4) @(posedge aclk);
    chk("overlap allowed", {gate_high, gate_low}, 32'h3F);
    rdchk(`REG_STATE, 32'h23F, "state overlap");
    u_motor_ctrl_model.drive(3'h0, 3'h0);
    repeat (3) @(posedge aclk);
    u_motor_ctrl_model.set_cc(1'b0);
    repeat (4) @(posedge aclk);
    u_motor_ctrl_model.drive(3'h7, 3'h7);
    repeat (4) @(posedge aclk);
    chk("overlap refused", {gate_high, gate_low}, 32'h07);
    rdchk(`REG_STATE, 32'h038, "state refused");
    u_motor_ctrl_model.drive(3'h0, 3'h0);
    done("cross conduction");
    blank_run(2'h2, d, ph);
    blank_run(2'h0, d, ph);
    boot_run(d);
    close_out();
  end
endmodule
